/* inc/sec_ctrl_pkg.sv */
// constants and carrier types for the in-line security control block
// Operation
// RULE_01: host writes zero to reserved bits
// RULE_02: receive guard at bit 9, resets high
// RULE_03: bit 8 picks first CBC-MAC byte
// RULE_04: first-byte select ignored inside CCM
// RULE_05: host should set bit 8 for 802.15.4
// RULE_06: three key selects at bits 7,6,5
// RULE_07: tag length code bits 4:2, reset 1
// RULE_08: mode field bits 1:0, reset off
// RULE_09: transmit length byte bits 14:8
// RULE_10: receive length byte bits 6:0
// RULE_11: CTR skips cleartext bytes before cipher
// RULE_12: CBC-MAC skips bytes before authentication
// RULE_13: CCM length is authenticated-only count
// RULE_14: length bytes ignored in stand-alone
// RULE_15: mode off passes frames untouched
package sec_ctrl_pkg;
   // ==========================================
   // register addresses
   localparam logic [5:0] ADDR_SECURITY_CONTROL_MAIN = 6'h19;
   localparam logic [5:0] ADDR_SECURITY_LENGTH_BYTES = 6'h1a;
   // ==========================================
   // field positions
   localparam int GUARD_BIT = 9;
   localparam int HEAD_BIT = 8;
   localparam int SA_KEY_BIT = 7;
   localparam int TX_KEY_BIT = 6;
   localparam int RX_KEY_BIT = 5;
   localparam int TAG_LSB = 2;
   localparam int MODE_LSB = 0;
   localparam int TXL_LSB = 8;
   localparam int RXL_LSB = 0;
   localparam logic [15:0] MAIN_WRITE_MASK = 16'h03ff;
   localparam logic [15:0] LEN_WRITE_MASK = 16'h7f7f;
   // ==========================================
   // reset values
   localparam logic [15:0] MAIN_RESET = 16'h03c4;
   localparam logic [15:0] LEN_RESET = 16'h0000;
   localparam logic [2:0] TAG_CODE_RESERVED = 3'h0;
   localparam logic [7:0] CBC_HEAD_OVERHEAD = 8'h02;
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_CBC_MAC,
      MODE_CTR,
      MODE_CCM
   } inline_protection_mode_e;
   // decoded settings toward the engine
   typedef struct packed {
      logic encrypt_en;
      logic auth_en;
      logic head_insert;
      logic key_choice;
      logic [6:0] skip_length;
      logic [4:0] tag_bytes;
   } engine_ctrl_s;
   typedef struct packed {
      logic [15:0] main_reg;
      logic [15:0] len_reg;
      logic [15:0] rdata;
      engine_ctrl_s tx;
      engine_ctrl_s rx;
      logic sa_key;
      logic guard;
      logic [7:0] tx_head_byte;
   } sec_state_s;
endpackage : sec_ctrl_pkg

/* core/inline_security_control.sv */
// in-line security configuration registers and their decode for the engine
`timescale 1ns/1ns
module inline_security_control
   import sec_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_write,
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [6:0] tx_frame_length,
   output logic [15:0] reg_rdata,
   output engine_ctrl_s tx_ctrl,
   output engine_ctrl_s rx_ctrl,
   output logic standalone_key_choice,
   output logic receive_buffer_guard_enable,
   output logic [7:0] tx_mac_head_byte
);
   sec_state_s st;
   sec_state_s next_st;

   // ==========================================
   // decode helper
   function automatic engine_ctrl_s decode(input logic [15:0] m, input logic key,
                                           input logic [6:0] len);
      engine_ctrl_s c;
      inline_protection_mode_e md;
      logic [2:0] code;
      md = inline_protection_mode_e'(m[MODE_LSB +: 2]); // see RULE_08
      code = m[TAG_LSB +: 3];
      c = '0;
      case (md)
         MODE_OFF: begin
            c = '0; // see RULE_15
         end
         MODE_CBC_MAC: begin
            c.auth_en = 1'b1;
            c.head_insert = m[HEAD_BIT]; // see RULE_03
         end
         MODE_CTR: begin
            c.encrypt_en = 1'b1; // see RULE_11
         end
         MODE_CCM: begin
            c.encrypt_en = 1'b1;
            c.auth_en = 1'b1;
            c.head_insert = 1'b0; // see RULE_04
         end
         default: begin
            c = '0;
         end
      endcase
      if (md != MODE_OFF) begin
         c.key_choice = key; // see RULE_06
         c.skip_length = len; // see RULE_12 see RULE_13
         // tag length M = 2*code + 2; code 0 reserved, treated as no tag
         if (c.auth_en && code != TAG_CODE_RESERVED) begin
            c.tag_bytes = {1'b0, code, 1'b0} + 5'd2; // see RULE_07
         end
      end
      return c;
   endfunction : decode

   // ==========================================
   // next state
   always_comb begin
      logic [7:0] hb;
      hb = '0;
      next_st = st;
      if (reg_write && reg_addr == ADDR_SECURITY_CONTROL_MAIN) begin
         next_st.main_reg = reg_wdata & MAIN_WRITE_MASK; // see RULE_01
      end
      if (reg_write && reg_addr == ADDR_SECURITY_LENGTH_BYTES) begin
         next_st.len_reg = reg_wdata & LEN_WRITE_MASK; // see RULE_09 see RULE_10
      end
      case (reg_addr)
         ADDR_SECURITY_CONTROL_MAIN: next_st.rdata = st.main_reg;
         ADDR_SECURITY_LENGTH_BYTES: next_st.rdata = st.len_reg;
         default: next_st.rdata = 16'h0000;
      endcase
      next_st.tx = decode(st.main_reg, st.main_reg[TX_KEY_BIT], st.len_reg[TXL_LSB +: 7]);
      next_st.rx = decode(st.main_reg, st.main_reg[RX_KEY_BIT], st.len_reg[RXL_LSB +: 7]);
      // stand-alone path sees only its key; length bytes do not reach it
      next_st.sa_key = st.main_reg[SA_KEY_BIT]; // see RULE_14
      next_st.guard = st.main_reg[GUARD_BIT]; // see RULE_02
      // transmit head: frame length minus skip length minus 2
      hb = {1'b0, tx_frame_length} - {1'b0, st.len_reg[TXL_LSB +: 7]} - CBC_HEAD_OVERHEAD;
      next_st.tx_head_byte = hb; // see RULE_03
   end

   // ==========================================
   // state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st <= '0;
         st.main_reg <= MAIN_RESET;
         st.len_reg <= LEN_RESET;
         st.guard <= 1'b1;
         st.sa_key <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign tx_ctrl = st.tx;
   assign rx_ctrl = st.rx;
   assign standalone_key_choice = st.sa_key;
   assign receive_buffer_guard_enable = st.guard;
   assign tx_mac_head_byte = st.tx_head_byte;
endmodule : inline_security_control

/* verification/host_model.sv */
// host model issuing configuration writes and reads
`timescale 1ns/1ns
module host_model
   import sec_ctrl_pkg::*;
(
   input wire logic clk,
   output logic reg_write,
   output logic [5:0] reg_addr,
   output logic [15:0] reg_wdata
);
   // called at a falling edge; holds the request over one rising edge
   task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic w);
      reg_write = w;
      reg_addr = a;
      reg_wdata = d & (a == 6'h19 ? MAIN_WRITE_MASK : LEN_WRITE_MASK);
      @(negedge clk);
   endtask : wr
endmodule : host_model

/* verification/sec_ctrl_asserts.sv */
// port assertions for the security control block
`timescale 1ns/1ns
module sec_ctrl_asserts
   import sec_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_write,
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire engine_ctrl_s tx_ctrl,
   input wire engine_ctrl_s rx_ctrl,
   input wire logic standalone_key_choice,
   input wire logic receive_buffer_guard_enable
);
   wire m = reg_write && reg_addr == 6'h19;
   wire l = reg_write && reg_addr == 6'h1a;
   wire [15:0] d = reg_wdata;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_g; $past(m,2) |-> receive_buffer_guard_enable == $past(d[9],2); endproperty
   a_g: assert property (p_g) else $error("guard");
   property p_k; $past(m,2) |-> standalone_key_choice == $past(d[7],2); endproperty
   a_k: assert property (p_k) else $error("sa key");
   property p_o; $past(m && d[1:0] == 0,2) |-> tx_ctrl == 0 && rx_ctrl == 0; endproperty
   a_o: assert property (p_o) else $error("off");
   property p_c; $past(m && d[1:0] == 1,2) |-> tx_ctrl.auth_en && !tx_ctrl.encrypt_en
      && tx_ctrl.head_insert == $past(d[8],2); endproperty
   a_c: assert property (p_c) else $error("cbc");
   property p_t; $past(m && d[1:0] == 2,2) |-> tx_ctrl.encrypt_en && tx_ctrl.tag_bytes == 0; endproperty
   a_t: assert property (p_t) else $error("ctr");
   property p_x; $past(m && d[1:0] == 3,2) |-> rx_ctrl.auth_en && !rx_ctrl.head_insert
      && rx_ctrl.key_choice == $past(d[5],2); endproperty
   a_x: assert property (p_x) else $error("ccm");
   property p_m; $past(m && d[1:0] == 1 && d[4:2] != 0,2) |->
      tx_ctrl.tag_bytes == $past(d[4:2],2) * 2 + 2; endproperty
   a_m: assert property (p_m) else $error("tag");
   property p_l; $past(l,2) && tx_ctrl.auth_en |-> tx_ctrl.skip_length == $past(d[14:8],2); endproperty
   a_l: assert property (p_l) else $error("skip");
   c_ccm: cover property (m && d[1:0] == 3);
   c_ctr: cover property (m && d[1:0] == 2);
   c_len: cover property (l);
endmodule : sec_ctrl_asserts
bind inline_security_control sec_ctrl_asserts i_sec_ctrl_asserts(.clk, .rst_b, .reg_write,
   .reg_addr, .reg_wdata, .tx_ctrl, .rx_ctrl, .standalone_key_choice, .receive_buffer_guard_enable);

/* verification/testbench.sv */
// self-checking bench for the security control block
`timescale 1ns/1ns
module testbench;
   import sec_ctrl_pkg::*;
   logic clk = 0, rst_b = 0, reg_write, gd, sak;
   logic [5:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, r = 16'h0013, el;
   logic [6:0] tx_frame_length = 7'h00;
   logic [7:0] hb;
   engine_ctrl_s tx_ctrl, rx_ctrl;
   int num_errors = 0, n_tests = 0;
   initial forever #4 clk = ~clk;
   host_model i_host_model(.clk, .reg_write, .reg_addr, .reg_wdata);
   inline_security_control i_inline_security_control(.clk, .rst_b, .reg_write, .reg_addr,
      .reg_wdata, .tx_frame_length, .reg_rdata, .tx_ctrl, .rx_ctrl, .standalone_key_choice(sak),
      .receive_buffer_guard_enable(gd), .tx_mac_head_byte(hb));
   function automatic logic [15:0] nx(logic [15:0] v); return {v[14:0], v[15]^v[13]^v[12]^v[10]}; endfunction : nx
   // expected engine settings from mode, key select and length byte
   function automatic logic [15:0] ec(logic [15:0] m, logic k, logic [6:0] n);
      engine_ctrl_s c;
      c = '0;
      if (m[1:0] != 2'h0) begin
         c.encrypt_en = m[1];
         c.auth_en = m[0];
         c.head_insert = (m[1:0] == 2'h1) && m[8];
         c.key_choice = k;
         c.skip_length = n;
         if (m[0] && m[4:2] != 3'h0) begin
            c.tag_bytes = 5'({2'h0, m[4:2]} * 2 + 2);
         end
      end
      return c;
   endfunction : ec
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      i_host_model.wr(a, 16'h0000, 1'b0);
      chk(reg_rdata, e);
   endtask : rd
   task automatic summarize;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      #100000 num_errors++;
      summarize;
   end
   initial begin
      i_host_model.wr(6'h00, 16'h0000, 1'b0);
      repeat (6) @(negedge clk);
      rst_b = 1;
      rd(6'h19, 16'h03c4);
      rd(6'h1a, 16'h0000);
      chk({15'h0000, gd}, 16'h0001);
      rd(6'h1b, 16'h0000);
      i_host_model.wr(6'h19, 16'h0109, 1'b1);
      rd(6'h19, 16'h0109);
      chk(tx_ctrl, ec(16'h0109, 1'b0, 7'h00));
      for (int i = 0; i < 60; i++) begin
         r = nx(r);
         el = nx(r) & 16'h7f7f;
         i_host_model.wr(6'h19, r, 1'b1);
         i_host_model.wr(6'h1a, nx(r), 1'b1);
         tx_frame_length = r[6:0];
         rd(6'h19, r & 16'h03ff);
         rd(6'h1a, el);
         chk({8'h00, hb}, {8'h00, 8'({1'b0, r[6:0]} - el[14:8] - 2)});
         chk(tx_ctrl, ec(r, r[6], el[14:8]));
         chk(rx_ctrl, ec(r, r[5], el[6:0]));
         chk({14'h0000, gd, sak}, {14'h0000, r[9], r[7]});
      end
      summarize;
   end
endmodule : testbench
